// file: common/shc_pkg.sv
package shc_pkg;

  // ----------------------------------------------------------------
  // Register map (word byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_CNT = 4'h8;

  // CTRL fields
  localparam int CTRL_OSC_KEEP = 0;
  localparam int CTRL_LOWPWR = 1;
  localparam int CTRL_CLKOUT_SUB = 2;
  localparam int CTRL_RESET_VAL = 0;

  // Option byte fields
  localparam int OPT_WDT_STBY = 0;
  localparam int OPT_WDT_EN = 4;

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FIH = 3'h0;
  localparam logic [2:0] SRC_FX = 3'h1;
  localparam logic [2:0] SRC_FEX = 3'h2;
  localparam logic [2:0] SRC_FXT = 3'h3;
  localparam logic [2:0] SRC_FEXS = 3'h4;

  // ----------------------------------------------------------------
  // Release waits, in clocks (maximum of each printed range)
  // ----------------------------------------------------------------
  localparam logic [3:0] WAIT_VEC_LP0 = 4'hb;
  localparam logic [3:0] WAIT_VEC_LP1 = 4'hc;
  localparam logic [3:0] WAIT_RES_LP0 = 4'h5;
  localparam logic [3:0] WAIT_RES_LP1 = 4'h6;
  localparam logic [3:0] WAIT_MAIN = 4'ha;
  localparam logic [3:0] WAIT_STOP = 4'h7;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b11,
    ST_WAKE = 2'b10
  } shc_state_e;

endpackage

// file: verif/shc_cpu_model.sv
`timescale 1ns/1ps
module shc_cpu_model
(
  // Clock
  input wire logic clk_i,
  // Requests towards the controller
  output logic halt_o,
  output logic stop_o,
  output logic [7:0] flag_o
);
  initial
  begin
    halt_o = 1'b0;
    stop_o = 1'b0;
    flag_o = 8'h00;
  end
  // Software has already stopped disabled functions
  task automatic issue(input logic is_stop);
    @(posedge clk_i);
    halt_o <= !is_stop;
    stop_o <= is_stop;
    @(posedge clk_i);
    halt_o <= 1'b0;
    stop_o <= 1'b0;
  endtask
  task automatic raise(input logic [7:0] f);
    @(posedge clk_i);
    flag_o <= f;
  endtask
endmodule

// file: verif/standby_halt_stop_control_tb.sv
`timescale 1ns/1ps
module standby_halt_stop_control_tb
  import shc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, rd, wr, ie, dma, crc, adc, csi, uart, i2c;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [7:0] mask, opt, flag;
  logic [2:0] src;
  logic waitreq, halt, stop, cpu_en, fast_internal_osc, fx, fex, subh, porth, slow_internal_osc, ram, crce, per, clko, serial_array, snz, vec, res;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  shc_cpu_model cpu_u (.clk_i(clk), .halt_o(halt), .stop_o(stop), .flag_o(flag));
  shc_standby_ctrl dut_u (.SYS_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .HALT_REQ_I(halt), .STOP_REQ_I(stop), .IE_I(ie), .IRQ_MASK_I(mask), .IRQ_FLAG_I(flag), .CLK_SRC_I(src),
    .OPTION_BYTE_I(opt), .DMA_ACTIVE_I(dma), .CRC_RAM_I(crc), .ADC_TRIG_I(adc), .CSI_RX_I(csi),
    .UART_RX_I(uart), .I2C_ADDR_MATCH_I(i2c), .CPU_CLK_EN_O(cpu_en), .FIH_EN_O(fast_internal_osc), .FX_EN_O(fx),
    .FEX_EN_O(fex), .SUBCLK_HOLD_O(subh), .PORT_HOLD_O(porth), .FIL_EN_O(slow_internal_osc), .RAM_EN_O(ram),
    .CRC_EN_O(crce), .PERIPH_EN_O(per), .CLKOUT_EN_O(clko), .SAU_OTHER_EN_O(serial_array), .SNOOZE_O(snz),
    .VECTOR_O(vec), .RESUME_O(res));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // Counts edges until the chosen wake pulse (at most 40), then checks the count against the range
  task automatic wake(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((v ? vec : res) !== 1'b1 && n < 40);
    n_tests++;
    if (n < lo + 1 || n > hi + 2)
    begin
      $display("unexpected wake_wait expected %0d seen %0d", hi + 1, n);
      n_errors++;
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rd, wr, ie, dma, crc, adc, csi, uart, i2c} = '0;
    addr = 4'h0;
    wdata = 32'h0;
    mask = 8'hfe;
    src = SRC_FIH;
    opt = 8'h00;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("cpu_en", 1, cpu_en);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl", CTRL_RESET_VAL, q);
    bus(1, ADDR_CTRL, 32'h1);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl", 1, q);
    bus(0, 4'hc, 0);
    chk("unmapped", 0, q);
    cpu_u.issue(0);
    settle();
    chk("cpu_en", 0, cpu_en);
    chk("fih", 1, fast_internal_osc);
    chk("fx", 0, fx);
    chk("hold", 2'b11, {subh, porth});
    chk("fil", 1, slow_internal_osc);
    chk("ram", 0, ram);
    chk("crc", 0, crce);
    dma <= 1'b1;
    crc <= 1'b1;
    ie <= 1'b1;
    settle();
    chk("ram", 1, ram);
    chk("crc", 1, crce);
    cpu_u.raise(8'h01);
    wake(1, 10, 10);
    cpu_u.issue(0);
    settle();
    chk("cpu_en", 1, cpu_en);
    cpu_u.raise(8'h00);
    bus(1, ADDR_CTRL, 32'h0);
    {dma, crc, ie} <= 3'b000;
    src <= SRC_FXT;
    opt <= 8'h11;
    cpu_u.issue(0);
    settle();
    chk("fil", 1, slow_internal_osc);
    chk("periph", 1, per);
    chk("fih", 0, fast_internal_osc);
    cpu_u.raise(8'h01);
    wake(0, 4, 5);
    cpu_u.raise(8'h00);
    ie <= 1'b1;
    cpu_u.issue(0);
    settle();
    mask <= 8'hff;
    cpu_u.raise(8'h01);
    settle();
    chk("cpu_en", 0, cpu_en);
    mask <= 8'hfe;
    wake(1, 10, 11);
    cpu_u.raise(8'h00);
    bus(1, ADDR_CTRL, 32'h2);
    opt <= 8'h10;
    ie <= 1'b1;
    cpu_u.issue(0);
    settle();
    chk("periph", 0, per);
    chk("fil", 0, slow_internal_osc);
    cpu_u.raise(8'h01);
    wake(1, 11, 12);
    cpu_u.raise(8'h00);
    ie <= 1'b0;
    cpu_u.issue(0);
    settle();
    cpu_u.raise(8'h01);
    wake(0, 5, 6);
    cpu_u.raise(8'h00);
    ie <= 1'b1;
    cpu_u.issue(1);
    settle();
    chk("cpu_en", 1, cpu_en);
    src <= SRC_FX;
    bus(1, ADDR_CTRL, 32'h4);
    cpu_u.issue(1);
    settle();
    chk("cpu_en", 0, cpu_en);
    chk("main", 0, {fast_internal_osc, fx, fex});
    chk("subh", 1, subh);
    chk("clkout", 1, clko);
    chk("sau", 0, serial_array);
    csi <= 1'b1;
    settle();
    chk("snooze", 1, snz);
    csi <= 1'b0;
    adc <= 1'b1;
    settle();
    chk("snooze", 1, snz);
    adc <= 1'b0;
    uart <= 1'b1;
    settle();
    chk("snooze", 1, snz);
    uart <= 1'b0;
    i2c <= 1'b1;
    wake(1, 7, 12);
    i2c <= 1'b0;
    cpu_u.raise(8'h01);
    cpu_u.issue(1);
    wake(1, 0, 12);
    cpu_u.raise(8'h00);
    cpu_u.issue(0);
    settle();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("cpu_en", 1, cpu_en);
    summarize();
  end
endmodule

// file: verilog/shc_standby_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Halt instruction enters halt from any clock
// - Pending unmasked interrupt blocks halt entry
// - CPU clock gated in halt and stop
// - Active oscillator runs, unused main sources off
// - Subclock and port latches held in halt
// - Slow oscillator from keep bit or option
// - RAM off in halt except DMA
// - CRC runs in halt only via DMA
// - Subclock halt: peripherals need low-power bit zero
// - Unmasked interrupt releases halt
// - Vector if acknowledge enabled, else resume
// - Subclock vectored wait 10-11 or 11-12
// - Subclock resume wait 4-5 or 5-6
// - Reset ends halt like normal reset
// - Stop only from main clock sources
// - Pending interrupt clears stop at once
// - Stop halts main sources, holds subclock
// - Timer-triggered conversion wakes converter to snooze
// - Only two serial channels wake in stop
// - I2C address match wakes from stop
// - Stop clock output needs subclock and bit zero
module shc_standby_ctrl
  import shc_pkg::*;
#(
  parameter int NUM_IRQ = 8
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // CPU and interrupt controller
  input wire logic HALT_REQ_I,
  input wire logic STOP_REQ_I,
  input wire logic IE_I,
  input wire logic [NUM_IRQ-1:0] IRQ_MASK_I,
  input wire logic [NUM_IRQ-1:0] IRQ_FLAG_I,
  input wire logic [2:0] CLK_SRC_I,
  input wire logic [7:0] OPTION_BYTE_I,
  input wire logic DMA_ACTIVE_I,
  input wire logic CRC_RAM_I,
  // Snooze wake sources and I2C stop release
  input wire logic ADC_TRIG_I,
  input wire logic CSI_RX_I,
  input wire logic UART_RX_I,
  input wire logic I2C_ADDR_MATCH_I,
  // Clock and function enables
  output logic CPU_CLK_EN_O,
  output logic FIH_EN_O,
  output logic FX_EN_O,
  output logic FEX_EN_O,
  output logic SUBCLK_HOLD_O,
  output logic PORT_HOLD_O,
  output logic FIL_EN_O,
  output logic RAM_EN_O,
  output logic CRC_EN_O,
  output logic PERIPH_EN_O,
  output logic CLKOUT_EN_O,
  output logic SAU_OTHER_EN_O,
  output logic SNOOZE_O,
  // Wake results
  output logic VECTOR_O,
  output logic RESUME_O
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  shc_state_e state_q, state_d;
  logic [2:0] ctrl_q;
  logic [3:0] cnt_q, cnt_d;
  logic vec_q, vec_d;
  logic ack_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic pend = |(~IRQ_MASK_I & IRQ_FLAG_I);
  wire logic on_sub = (CLK_SRC_I == SRC_FXT) || (CLK_SRC_I == SRC_FEXS);
  wire logic on_main = (CLK_SRC_I == SRC_FIH) || (CLK_SRC_I == SRC_FX) || (CLK_SRC_I == SRC_FEX);
  wire logic lowpwr = ctrl_q[CTRL_LOWPWR];
  wire logic halt_go = HALT_REQ_I && !pend;
  wire logic stop_go = STOP_REQ_I && on_main && !HALT_REQ_I;
  wire logic [3:0] wait_halt = !on_sub ? WAIT_MAIN
                             : IE_I ? (lowpwr ? WAIT_VEC_LP1 : WAIT_VEC_LP0)
                             : (lowpwr ? WAIT_RES_LP1 : WAIT_RES_LP0);
  wire logic in_halt = state_d == ST_HALT;
  wire logic in_stop = state_d == ST_STOP;
  wire logic stby = in_halt || in_stop;
  wire logic snooze_req = in_stop && (ADC_TRIG_I || CSI_RX_I || UART_RX_I);
  wire logic fil_on = ctrl_q[CTRL_OSC_KEEP]
                   || (OPTION_BYTE_I[OPT_WDT_EN] && OPTION_BYTE_I[OPT_WDT_STBY]);
  wire logic bus_req = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  wire logic [31:0] rd_mux = (AVS_ADDRESS_I == ADDR_CTRL) ? {29'h0, ctrl_q}
                           : (AVS_ADDRESS_I == ADDR_STAT) ? {29'h0, vec_q, state_q}
                           : (AVS_ADDRESS_I == ADDR_CNT) ? {28'h0, cnt_q}
                           : 32'h0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    vec_d = vec_q;
    case (state_q)
      ST_RUN:
      begin
        if (halt_go)
        begin
          state_d = ST_HALT;
        end
        else if (stop_go)
        begin
          if (pend)
          begin
            state_d = ST_WAKE;
            cnt_d = WAIT_STOP;
            vec_d = IE_I;
          end
          else
          begin
            state_d = ST_STOP;
          end
        end
      end
      ST_HALT:
      begin
        if (pend)
        begin
          state_d = ST_WAKE;
          cnt_d = wait_halt;
          vec_d = IE_I;
        end
      end
      ST_STOP:
      begin
        if (pend || I2C_ADDR_MATCH_I)
        begin
          state_d = ST_WAKE;
          cnt_d = WAIT_STOP;
          vec_d = IE_I;
        end
      end
      ST_WAKE:
      begin
        if (cnt_q <= 4'h1)
        begin
          state_d = ST_RUN;
          cnt_d = 4'h0;
        end
        else
        begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      state_q <= ST_RUN;
      cnt_q <= 4'h0;
      vec_q <= 1'b0;
      CPU_CLK_EN_O <= 1'b1;
      FIH_EN_O <= 1'b1;
      FX_EN_O <= 1'b0;
      FEX_EN_O <= 1'b0;
      SUBCLK_HOLD_O <= 1'b0;
      PORT_HOLD_O <= 1'b0;
      FIL_EN_O <= 1'b1;
      RAM_EN_O <= 1'b1;
      CRC_EN_O <= 1'b1;
      PERIPH_EN_O <= 1'b1;
      CLKOUT_EN_O <= 1'b1;
      SAU_OTHER_EN_O <= 1'b1;
      SNOOZE_O <= 1'b0;
      VECTOR_O <= 1'b0;
      RESUME_O <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      vec_q <= vec_d;
      CPU_CLK_EN_O <= !stby;
      FIH_EN_O <= in_stop ? 1'b0 : (!stby || CLK_SRC_I == SRC_FIH);
      FX_EN_O <= in_stop ? 1'b0 : (CLK_SRC_I == SRC_FX);
      FEX_EN_O <= in_stop ? 1'b0 : (CLK_SRC_I == SRC_FEX);
      SUBCLK_HOLD_O <= stby;
      PORT_HOLD_O <= stby;
      FIL_EN_O <= !stby || fil_on;
      RAM_EN_O <= !stby || DMA_ACTIVE_I;
      CRC_EN_O <= !stby || (in_halt && DMA_ACTIVE_I && CRC_RAM_I);
      PERIPH_EN_O <= !stby || (in_halt && (!on_sub || !lowpwr));
      CLKOUT_EN_O <= !stby || (in_halt && (!on_sub || !lowpwr))
                  || (in_stop && ctrl_q[CTRL_CLKOUT_SUB] && !lowpwr);
      SAU_OTHER_EN_O <= !in_stop && (!in_halt || !on_sub || !lowpwr);
      SNOOZE_O <= snooze_req;
      VECTOR_O <= (state_q == ST_WAKE) && (state_d == ST_RUN) && vec_q;
      RESUME_O <= (state_q == ST_WAKE) && (state_d == ST_RUN) && !vec_q;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      ctrl_q <= CTRL_RESET_VAL[2:0];
      ack_q <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0;
    end
    else
    begin
      ack_q <= bus_req;
      AVS_WAITREQUEST_O <= !bus_req;
      AVS_READDATA_O <= rd_mux;
      if (bus_req && AVS_WRITE_I && AVS_ADDRESS_I == ADDR_CTRL)
      begin
        ctrl_q <= AVS_WRITEDATA_I[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_HALT_ENTER: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_RUN && HALT_REQ_I && !pend) |=> state_q == ST_HALT)
    else $error("halt not entered");
  AST_HALT_BLOCK: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_RUN && pend) |=> state_q != ST_HALT)
    else $error("halt entered with pending irq");
  AST_CPU_GATE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT || state_q == ST_STOP) |-> !CPU_CLK_EN_O)
    else $error("cpu clock running in standby");
  AST_STOP_MAIN: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_STOP |-> !FIH_EN_O && !FX_EN_O && !FEX_EN_O)
    else $error("main osc running in stop");
  AST_HALT_WAKE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && pend) |=> state_q == ST_WAKE)
    else $error("halt not released");
  AST_STOP_SUB: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_RUN && on_sub && !HALT_REQ_I) |=> state_q != ST_STOP)
    else $error("stop from subclock");
  AST_SUB_VEC_WAIT: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && pend && on_sub && IE_I && !lowpwr) |=> ##11 VECTOR_O)
    else $error("vectored wait wrong");
  AST_SUB_RES_WAIT: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && pend && on_sub && !IE_I && lowpwr) |=> ##6 RESUME_O)
    else $error("resume wait wrong");
  AST_RAM: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && $past(state_q) == ST_HALT && !$past(DMA_ACTIVE_I)) |-> !RAM_EN_O)
    else $error("ram active in halt");
  AST_RESET: assert property (@(posedge SYS_CLK_I)
    !RESETN_I |=> state_q == ST_RUN && CPU_CLK_EN_O)
    else $error("reset not to run");
  AST_STOP_ENTER: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_RUN && STOP_REQ_I && on_main && !HALT_REQ_I && !pend) |=> state_q == ST_STOP)
    else $error("stop not entered");
  AST_STOP_PEND: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_RUN && STOP_REQ_I && on_main && !HALT_REQ_I && pend) |=> state_q == ST_WAKE && cnt_q == WAIT_STOP)
    else $error("stop not cleared at once");
  AST_STOP_WAKE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_STOP && (pend || I2C_ADDR_MATCH_I)) |=> state_q == ST_WAKE)
    else $error("stop not released");
  AST_HALT_STAY: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && !pend) |=> state_q == ST_HALT)
    else $error("halt left without request");
  AST_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT || state_q == ST_STOP) |-> SUBCLK_HOLD_O && PORT_HOLD_O)
    else $error("holds released in standby");
  AST_STOP_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_STOP |-> SUBCLK_HOLD_O)
    else $error("subclock not held in stop");
  AST_HALT_FX: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && $past(CLK_SRC_I) == SRC_FX) |-> FX_EN_O && !FIH_EN_O && !FEX_EN_O)
    else $error("wrong main osc in halt");
  AST_HALT_SUB_OSC: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && $past(on_sub)) |-> !FIH_EN_O && !FX_EN_O && !FEX_EN_O)
    else $error("main osc running in subclock halt");
  AST_FIL: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT || state_q == ST_STOP) |-> FIL_EN_O == ($past(ctrl_q[CTRL_OSC_KEEP])
    || ($past(OPTION_BYTE_I[OPT_WDT_EN]) && $past(OPTION_BYTE_I[OPT_WDT_STBY]))))
    else $error("slow osc enable wrong");
  AST_RAM_DMA: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_HALT |-> RAM_EN_O == $past(DMA_ACTIVE_I))
    else $error("ram enable wrong in halt");
  AST_CRC: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_HALT |-> CRC_EN_O == ($past(DMA_ACTIVE_I) && $past(CRC_RAM_I)))
    else $error("crc enable wrong in halt");
  AST_PERIPH: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && $past(on_sub)) |-> PERIPH_EN_O == !$past(lowpwr))
    else $error("peripheral enable wrong");
  AST_SAU_STOP: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_STOP |-> !SAU_OTHER_EN_O)
    else $error("serial channels running in stop");
  AST_SNOOZE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_STOP && !pend && !I2C_ADDR_MATCH_I && (ADC_TRIG_I || CSI_RX_I || UART_RX_I)) |=> SNOOZE_O)
    else $error("snooze not raised");
  AST_CLKOUT_STOP: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_STOP |-> CLKOUT_EN_O == ($past(ctrl_q[CTRL_CLKOUT_SUB]) && !$past(lowpwr)))
    else $error("clock output enable wrong in stop");

  // ----------------------------------------------------------------
  // Checks: wake timing
  // ----------------------------------------------------------------
  // Pulses are registered, so they land one clock after the count ends
  AST_WAKE_VEC: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_WAKE && cnt_q <= 4'h1 && vec_q) |=> VECTOR_O && !RESUME_O)
    else $error("vector pulse missing");
  AST_WAKE_RESUME: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_WAKE && cnt_q <= 4'h1 && !vec_q) |=> RESUME_O && !VECTOR_O)
    else $error("resume pulse missing");
  AST_WAKE_COUNT: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_WAKE && cnt_q > 4'h1) |=> state_q == ST_WAKE && cnt_q == $past(cnt_q) - 4'h1)
    else $error("wake count skipped");
  AST_WAKE_CPU: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_WAKE |-> CPU_CLK_EN_O)
    else $error("cpu clock off after release");
  AST_SUB_VEC_LP1: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && pend && on_sub && IE_I && lowpwr) |=> ##12 VECTOR_O)
    else $error("low power vectored wait wrong");
  AST_SUB_RES_LP0: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (state_q == ST_HALT && pend && on_sub && !IE_I && !lowpwr) |=> ##5 RESUME_O)
    else $error("resume wait wrong at full power");

  // ----------------------------------------------------------------
  // Checks: register bus
  // ----------------------------------------------------------------
  // One wait state only; a slower answer would stall the master
  AST_BUS_ACK: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    ((AVS_READ_I || AVS_WRITE_I) && !ack_q) |=> !AVS_WAITREQUEST_O)
    else $error("bus not acknowledged");
  AST_BUS_ONE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("acknowledge longer than one cycle");
  AST_CTRL_WRITE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    (bus_req && AVS_WRITE_I && AVS_ADDRESS_I == ADDR_CTRL) |=> ctrl_q == $past(AVS_WRITEDATA_I[2:0]))
    else $error("control write lost");

  COV_HALT: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_HALT ##1 state_q == ST_WAKE);
  COV_STOP: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == ST_STOP ##1 state_q == ST_WAKE);
  COV_VEC: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) VECTOR_O);
  COV_RESUME: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) RESUME_O);
  COV_SNOOZE: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) SNOOZE_O);

endmodule
